// *** shared/flash_prog_consts.svh ***
// Purpose: Named constants of the programmer-mode flash port
// Assumes: Included by the package and by the design files
// Notes: Guarded against double inclusion
`ifndef FLASH_PROG_CONSTS_SVH
`define FLASH_PROG_CONSTS_SVH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define FP_ADDR_W 19
`define FP_BOOT_AW 13
`define FP_BLK_W 7
`define FP_BLK_LAST 7'h7F

// ----------------------------------------------------------------
// Command bytes
// ----------------------------------------------------------------
`define FP_CMD_READ_MAIN 8'h00
`define FP_CMD_READ_BOOT 8'h05
`define FP_CMD_PROG_MAIN 8'h40
`define FP_CMD_PROG_BOOT 8'h45
`define FP_CMD_ERASE_MAIN 8'h20
`define FP_CMD_ERASE_BOOT 8'h25
`define FP_CMD_STATUS 8'h71
`define FP_ERASED 8'hFF

// ----------------------------------------------------------------
// Status code and polling bits
// ----------------------------------------------------------------
`define FP_ST_ABN 7
`define FP_ST_CMD 6
`define FP_ST_PRG 5
`define FP_ST_ERS 4
`define FP_ST_CNT 1
`define FP_ST_ADR 0
`define FP_POLL_BUSY 2'b00
`define FP_POLL_ABN 2'b10
`define FP_POLL_OK 2'b11

// ----------------------------------------------------------------
// Wishbone register map
// ----------------------------------------------------------------
`define FP_REG_CTRL 8'h00
`define FP_REG_STATE 8'h04
`define FP_REG_IRQ_STAT 8'h08
`define FP_REG_IRQ_MASK 8'h0C
`define FP_CTRL_EN 0
`define FP_IRQ_PROG 0
`define FP_IRQ_ERASE 1
`define FP_IRQ_ERR 2
`define FP_IRQ_W 3

`endif

// *** shared/flash_prog_pkg.sv ***
// Purpose: Types of the programmer-mode flash port
// Assumes: Constants come from the guarded header
// Notes: One-bit steps from load to program and from program to idle
package flash_prog_pkg;
  `include "flash_prog_consts.svh"

  typedef logic [`FP_ADDR_W-1:0] addr_t;
  typedef logic [7:0] byte_t;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b000,
    SEQ_CMD2  = 3'b001,
    SEQ_LOAD  = 3'b011,
    SEQ_PROG  = 3'b010,
    SEQ_ERASE = 3'b110
  } seq_state_e;

  typedef enum logic [1:0] {
    OUT_ARRAY  = 2'b00,
    OUT_POLL   = 2'b01,
    OUT_STATUS = 2'b11
  } out_mode_e;
endpackage

// *** shared/flash_array_if.sv ***
// Purpose: Port between the sequencer and the array storage
// Assumes: Read data is combinational from the addressed byte
// Notes: One write port, one read port, shared address
`timescale 1ns/10ps
interface flash_array_if;
  import flash_prog_pkg::*;
  logic wr_en;
  logic boot_sel;
  addr_t addr;
  byte_t wdata;
  byte_t rdata;
  modport seq (output wr_en, output boot_sel, output addr, output wdata, input rdata);
  modport mem (input wr_en, input boot_sel, input addr, input wdata, output rdata);
endinterface

// *** rtl/flash_array_store.sv ***
// Purpose: Main and boot flash arrays held in flip-flops
// Assumes: Contents survive reset, as flash would
// Notes: Contents are unknown until erased or programmed
`timescale 1ns/10ps
`include "flash_prog_consts.svh"
module flash_array_store #(
  parameter int MAIN_AW = `FP_ADDR_W,
  parameter int BOOT_AW = `FP_BOOT_AW
) (
  input wire logic clk_i,
  flash_array_if.mem arr
);
  import flash_prog_pkg::*;

  byte_t main_mem [2**MAIN_AW];
  byte_t boot_mem [2**BOOT_AW];

  always_ff @(posedge clk_i) begin
    if (arr.wr_en && arr.boot_sel) begin
      boot_mem[arr.addr[BOOT_AW-1:0]] <= arr.wdata;
    end
    if (arr.wr_en && !arr.boot_sel) begin
      main_mem[arr.addr[MAIN_AW-1:0]] <= arr.wdata;
    end
  end

  // Boot reads above its space wrap, so their data is of no meaning
  assign arr.rdata = arr.boot_sel ? boot_mem[arr.addr[BOOT_AW-1:0]] : main_mem[arr.addr[MAIN_AW-1:0]];
endmodule

// *** rtl/flash_programmer_mode_port.sv ***
// Purpose: Programmer-mode parallel command port of the on-chip flash
// Assumes: Pins are asynchronous to clk_i and pass two flip-flops
// Notes: Wishbone slave for control, state and interrupts
// Operation
// - Decode chip, output and write enables
// - Memory read returns one byte per access
// - Read command 00 main, 05 boot
// - Program command is 129 writes
// - Program 128 bytes at once, poll
// - Erase command 20/25 twice, whole array
// - Status command 71 twice, shows errors
// - Data pin 6 shows normal completion
// - After operations, wait for next command
// - Memory read accepts commands like waiting
// - Consecutive reads need no more commands
// - Reset enters memory read mode
// - Chip disable floats data, logic runs
// - Polling pins 7 and 6 show progress
// - Status code bit layout of errors
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`include "flash_prog_consts.svh"
module flash_programmer_mode_port #(
  parameter int MAIN_AW = `FP_ADDR_W,
  parameter int BOOT_AW = `FP_BOOT_AW
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire flash_prog_pkg::addr_t addr_i,
  input wire flash_prog_pkg::byte_t data_i,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o
);
  import flash_prog_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] ctl_s1_ff;
  logic [2:0] ctl_s2_ff;
  logic we_prev_ff;
  addr_t addr_s1_ff;
  addr_t addr_s2_ff;
  byte_t data_s1_ff;
  byte_t data_s2_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_s1_ff <= 3'h7;
      ctl_s2_ff <= 3'h7;
      we_prev_ff <= 1'b1;
    end else begin
      ctl_s1_ff <= {we_n_i, oe_n_i, ce_n_i};
      ctl_s2_ff <= ctl_s1_ff;
      we_prev_ff <= ctl_s2_ff[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_s1_ff <= '0;
      addr_s2_ff <= '0;
      data_s1_ff <= 8'h00;
      data_s2_ff <= 8'h00;
    end else begin
      addr_s1_ff <= addr_i;
      addr_s2_ff <= addr_s1_ff;
      data_s1_ff <= data_i;
      data_s2_ff <= data_s1_ff;
    end
  end

  logic ce_n;
  logic oe_n;
  logic we_n;
  logic port_en_ff;
  logic cmd_wr;
  logic rd_active;

  assign ce_n = ctl_s2_ff[0];
  assign oe_n = ctl_s2_ff[1];
  assign we_n = ctl_s2_ff[2];
  // A write is taken at the rising edge of write-enable, data then being settled
  assign cmd_wr = port_en_ff && we_n && !we_prev_ff && !ce_n && oe_n;
  assign rd_active = !ce_n && !oe_n && we_n;

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  seq_state_e state_ff;
  out_mode_e out_mode_ff;
  logic array_select_ff;
  byte_t first_cmd_ff;
  addr_t cnt_ff;
  addr_t base_ff;
  logic adr_err_ff;
  logic ovr_err_ff;
  byte_t status_code_ff;
  logic [1:0] poll_ff;
  byte_t blk_buf [2**`FP_BLK_W];

  flash_array_if arr ();

  flash_array_store #(
    .MAIN_AW(MAIN_AW),
    .BOOT_AW(BOOT_AW)
  ) u_store (
    .clk_i(clk_i),
    .arr(arr)
  );

  logic prog_byte_live;
  logic prog_byte_ovr;
  logic prog_last;
  logic erase_last;
  addr_t erase_top;
  logic cmd_bad;
  logic cmd_known;

  assign erase_top = array_select_ff ? addr_t'(2**BOOT_AW - 1) : addr_t'(2**MAIN_AW - 1);
  assign prog_last = (state_ff == SEQ_PROG) && (cnt_ff[`FP_BLK_W-1:0] == `FP_BLK_LAST);
  assign erase_last = (state_ff == SEQ_ERASE) && (cnt_ff == erase_top);
  // Erased bytes and 0xFF fill bytes are left alone; a bad block address writes nothing
  assign prog_byte_live = (state_ff == SEQ_PROG) && !adr_err_ff
    && (blk_buf[cnt_ff[`FP_BLK_W-1:0]] != `FP_ERASED);
  // Programming over a byte that is not erased cannot succeed
  assign prog_byte_ovr = prog_byte_live && (arr.rdata != `FP_ERASED);

  assign cmd_known = (data_s2_ff == `FP_CMD_READ_MAIN) || (data_s2_ff == `FP_CMD_READ_BOOT)
    || (data_s2_ff == `FP_CMD_PROG_MAIN) || (data_s2_ff == `FP_CMD_PROG_BOOT)
    || (data_s2_ff == `FP_CMD_ERASE_MAIN) || (data_s2_ff == `FP_CMD_ERASE_BOOT)
    || (data_s2_ff == `FP_CMD_STATUS);
  assign cmd_bad = cmd_wr && (((state_ff == SEQ_IDLE) && !cmd_known)
    || ((state_ff == SEQ_CMD2) && (data_s2_ff != first_cmd_ff)));

  always_comb begin
    arr.boot_sel = array_select_ff;
    arr.wr_en = 1'b0;
    arr.wdata = `FP_ERASED;
    arr.addr = addr_s2_ff;
    if (state_ff == SEQ_PROG) begin
      arr.addr = base_ff | addr_t'(cnt_ff[`FP_BLK_W-1:0]);
      arr.wdata = blk_buf[cnt_ff[`FP_BLK_W-1:0]];
      arr.wr_en = prog_byte_live && !prog_byte_ovr;
    end else if (state_ff == SEQ_ERASE) begin
      arr.addr = cnt_ff;
      arr.wr_en = 1'b1;
    end
  end

  // Writes during program or erase are ignored; the part is busy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= SEQ_IDLE;
      out_mode_ff <= OUT_ARRAY;
      array_select_ff <= 1'b0;
      first_cmd_ff <= 8'h00;
      cnt_ff <= '0;
    end else begin
      case (state_ff)
        SEQ_IDLE: begin
          // Memory read and command wait share this state
          if (cmd_wr) begin
            first_cmd_ff <= data_s2_ff;
            cnt_ff <= '0;
            case (data_s2_ff)
              `FP_CMD_READ_MAIN, `FP_CMD_READ_BOOT: begin
                out_mode_ff <= OUT_ARRAY;
                array_select_ff <= (data_s2_ff == `FP_CMD_READ_BOOT);
              end
              `FP_CMD_PROG_MAIN, `FP_CMD_PROG_BOOT: begin
                state_ff <= SEQ_LOAD;
                array_select_ff <= (data_s2_ff == `FP_CMD_PROG_BOOT);
                out_mode_ff <= OUT_POLL;
              end
              `FP_CMD_ERASE_MAIN, `FP_CMD_ERASE_BOOT, `FP_CMD_STATUS: begin
                state_ff <= SEQ_CMD2;
              end
              default: begin
                out_mode_ff <= OUT_POLL;
              end
            endcase
          end
        end
        SEQ_CMD2: begin
          if (cmd_wr) begin
            state_ff <= SEQ_IDLE;
            if (data_s2_ff != first_cmd_ff) begin
              out_mode_ff <= OUT_POLL;
            end else if (first_cmd_ff == `FP_CMD_STATUS) begin
              out_mode_ff <= OUT_STATUS;
            end else begin
              state_ff <= SEQ_ERASE;
              array_select_ff <= (first_cmd_ff == `FP_CMD_ERASE_BOOT);
              out_mode_ff <= OUT_POLL;
            end
          end
        end
        SEQ_LOAD: begin
          if (cmd_wr) begin
            cnt_ff <= cnt_ff + addr_t'(1);
            if (cnt_ff[`FP_BLK_W-1:0] == `FP_BLK_LAST) begin
              state_ff <= SEQ_PROG;
              cnt_ff <= '0;
            end
          end
        end
        SEQ_PROG: begin
          cnt_ff <= cnt_ff + addr_t'(1);
          if (prog_last) begin
            state_ff <= SEQ_IDLE;
          end
        end
        SEQ_ERASE: begin
          cnt_ff <= cnt_ff + addr_t'(1);
          if (erase_last) begin
            state_ff <= SEQ_IDLE;
          end
        end
        default: begin
          state_ff <= SEQ_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Block buffer and block address
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (state_ff == SEQ_LOAD && cmd_wr) begin
      blk_buf[cnt_ff[`FP_BLK_W-1:0]] <= data_s2_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base_ff <= '0;
      adr_err_ff <= 1'b0;
    end else if (state_ff == SEQ_LOAD && cmd_wr && cnt_ff == '0) begin
      // Only the first data cycle carries the block address
      base_ff <= {addr_s2_ff[`FP_ADDR_W-1:`FP_BLK_W], `FP_BLK_W'(0)};
      adr_err_ff <= (addr_s2_ff[`FP_BLK_W-1:0] != '0)
        || (array_select_ff && (addr_s2_ff >> BOOT_AW) != '0);
    end
  end

  // ----------------------------------------------------------------
  // Status code and polling flags
  // ----------------------------------------------------------------
  logic op_start;
  logic op_accept;

  assign op_start = cmd_wr && (((state_ff == SEQ_IDLE)
    && (data_s2_ff == `FP_CMD_PROG_MAIN || data_s2_ff == `FP_CMD_PROG_BOOT))
    || ((state_ff == SEQ_CMD2) && (data_s2_ff == first_cmd_ff) && (first_cmd_ff != `FP_CMD_STATUS)));
  // Any command other than status read discards the previous result
  assign op_accept = cmd_wr && (state_ff == SEQ_IDLE) && (data_s2_ff != `FP_CMD_STATUS);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_code_ff <= 8'h00;
      poll_ff <= `FP_POLL_BUSY;
      ovr_err_ff <= 1'b0;
    end else begin
      if (op_accept) begin
        status_code_ff <= 8'h00;
        ovr_err_ff <= 1'b0;
      end
      if (op_start) begin
        poll_ff <= `FP_POLL_BUSY;
      end
      if (prog_byte_ovr) begin
        ovr_err_ff <= 1'b1;
      end
      if (cmd_bad) begin
        status_code_ff <= 8'h00;
        status_code_ff[`FP_ST_ABN] <= 1'b1;
        status_code_ff[`FP_ST_CMD] <= 1'b1;
        poll_ff <= `FP_POLL_ABN;
      end
      if (prog_last) begin
        status_code_ff[`FP_ST_ABN] <= adr_err_ff || ovr_err_ff || prog_byte_ovr;
        status_code_ff[`FP_ST_PRG] <= adr_err_ff || ovr_err_ff || prog_byte_ovr;
        status_code_ff[`FP_ST_CNT] <= ovr_err_ff || prog_byte_ovr;
        status_code_ff[`FP_ST_ADR] <= adr_err_ff;
        poll_ff <= (adr_err_ff || ovr_err_ff || prog_byte_ovr) ? `FP_POLL_ABN : `FP_POLL_OK;
      end
      if (erase_last) begin
        poll_ff <= `FP_POLL_OK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data pin drive
  // ----------------------------------------------------------------
  byte_t dout_ff;
  logic doe_n_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dout_ff <= 8'h00;
      doe_n_ff <= 1'b1;
    end else begin
      // Chip disable only floats the pins; the sequencer keeps running
      doe_n_ff <= !rd_active;
      case (out_mode_ff)
        OUT_ARRAY: dout_ff <= arr.rdata;
        OUT_POLL: dout_ff <= {poll_ff, 6'h00};
        OUT_STATUS: dout_ff <= status_code_ff;
        default: dout_ff <= 8'h00;
      endcase
    end
  end

  assign data_o = dout_ff;
  assign data_oe_n_o = doe_n_ff;

  // ----------------------------------------------------------------
  // Wishbone slave and interrupts
  // ----------------------------------------------------------------
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [`FP_IRQ_W-1:0] irq_stat_ff;
  logic [`FP_IRQ_W-1:0] irq_mask_ff;
  logic [`FP_IRQ_W-1:0] irq_ev;
  logic [`FP_IRQ_W-1:0] irq_clr;
  logic wb_req;
  logic wb_wr_take;

  assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wb_wr_take = wb_cyc_i && wb_stb_i && ack_ff && wb_we_i && wb_sel_i[0];
  assign irq_ev = {cmd_bad || (prog_last && (adr_err_ff || ovr_err_ff || prog_byte_ovr)), erase_last, prog_last};
  // Clear only the bits that were returned, so a later event survives
  assign irq_clr = (wb_cyc_i && wb_stb_i && ack_ff && !wb_we_i && wb_adr_i == `FP_REG_IRQ_STAT)
    ? dat_ff[`FP_IRQ_W-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= wb_req;
      if (wb_req) begin
        case (wb_adr_i)
          `FP_REG_CTRL: dat_ff <= {31'h0000_0000, port_en_ff};
          `FP_REG_STATE: dat_ff <= {14'h0000, poll_ff, status_code_ff, 2'b00, array_select_ff, out_mode_ff, state_ff};
          `FP_REG_IRQ_STAT: dat_ff <= {29'h0000_0000, irq_stat_ff};
          `FP_REG_IRQ_MASK: dat_ff <= {29'h0000_0000, irq_mask_ff};
          default: dat_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_en_ff <= 1'b1;
      irq_mask_ff <= '0;
    end else if (wb_wr_take) begin
      if (wb_adr_i == `FP_REG_CTRL) begin
        port_en_ff <= wb_dat_i[`FP_CTRL_EN];
      end
      if (wb_adr_i == `FP_REG_IRQ_MASK) begin
        irq_mask_ff <= wb_dat_i[`FP_IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_ev;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign irq_o = |(irq_stat_ff & irq_mask_ff);
endmodule

// *** tb/flash_port_properties.sv ***
// Purpose: Port checker for the programmer-mode flash port
// Assumes: Sees only the top module ports
// Notes: Pin paths carry three clocks of latency
`timescale 1ns/10ps
module flash_port_properties (
  input logic clk_i,
  input logic rst_i,
  input logic ce_n_i,
  input logic oe_n_i,
  input logic we_n_i,
  input logic data_oe_n_o,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  input logic irq_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_one_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_rsp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  unmapped_a: assert property (wb_ack_o && !$past(wb_we_i) &&
    !($past(wb_adr_i) inside {8'h00, 8'h04, 8'h08, 8'h0C}) |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  hi_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:18] == 14'h0000)
    else $error("unused read bits set");
  reset_out_a: assert property (disable iff (1'b0) rst_i |=> data_oe_n_o && !wb_ack_o && !irq_o)
    else $error("outputs active after reset");
  chip_off_a: assert property (ce_n_i [*4] |-> data_oe_n_o)
    else $error("data driven while chip disabled");
  out_off_a: assert property (oe_n_i [*4] |-> data_oe_n_o)
    else $error("data driven while output disabled");
  drive_on_a: assert property ((!ce_n_i && !oe_n_i && we_n_i) [*4] |-> !data_oe_n_o)
    else $error("read access not driven");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(wb_ack_o))
    else $error("interrupt dropped without bus access");
  cover property (!data_oe_n_o);
  cover property (irq_o);
  cover property (wb_ack_o && $past(wb_we_i));
endmodule

bind flash_programmer_mode_port flash_port_properties chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .ce_n_i(ce_n_i), .oe_n_i(oe_n_i), .we_n_i(we_n_i), .data_oe_n_o(data_oe_n_o),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));

// *** tb/prom_prog_model.sv ***
// Purpose: Model of the external PROM programmer
// Assumes: Pins change just after a rising clock edge
// Notes: Data lines toggle when released, not held
`timescale 1ns/10ps
module prom_prog_model (
  input logic clk_i,
  input flash_prog_pkg::byte_t data_i,
  input logic data_oe_n_i,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output flash_prog_pkg::addr_t addr_o,
  output flash_prog_pkg::byte_t data_o
);
  import flash_prog_pkg::*;
  initial begin
    ce_n_o = 1'b1;
    oe_n_o = 1'b1;
    we_n_o = 1'b1;
    addr_o = 19'h0_0000;
    data_o = 8'h5A;
  end
  // ----------------------------------------
  // Pin cycles
  // ----------------------------------------
  // Command write: ce low, oe high, we pulsed low
  task pwr(input addr_t a, input byte_t d);
    @(posedge clk_i);
    ce_n_o <= 1'b0;
    addr_o <= a;
    data_o <= d;
    @(posedge clk_i);
    we_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    we_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    ce_n_o <= 1'b1;
    data_o <= ~d;
  endtask
  // Read: returns {output enable, data} seen after the sync latency
  task prd(input addr_t a, output logic [8:0] q);
    @(posedge clk_i);
    ce_n_o <= 1'b0;
    oe_n_o <= 1'b0;
    addr_o <= a;
    data_o <= ~data_o;
    repeat (5) @(posedge clk_i);
    q = {data_oe_n_i, data_i};
    oe_n_o <= 1'b1;
    ce_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// *** tb/flash_programmer_mode_port_tb_top.sv ***
// Purpose: Self-checking bench of the programmer-mode flash port
// Assumes: Arrays shrunk to 256 and 64 bytes to keep erase short
// Notes: Bus cycles wait for the acknowledge, pin cycles have fixed length; a timeout bounds the run
`timescale 1ns/10ps
module flash_programmer_mode_port_tb_top;
  import flash_prog_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_n, oe_n, we_n, oen, irq, ack;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] wadr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  addr_t adr;
  byte_t din, dout;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc_cnt = 0;

  flash_programmer_mode_port #(.MAIN_AW(8), .BOOT_AW(6)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(adr), .data_i(din), .data_o(dout),
    .data_oe_n_o(oen), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(wadr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq));
  prom_prog_model prog_u (.clk_i(clk_i), .data_i(dout), .data_oe_n_i(oen), .ce_n_o(ce_n),
    .oe_n_o(oe_n), .we_n_o(we_n), .addr_o(adr), .data_o(din));

  // ----------------------------------------
  // Clock, timeout, helpers
  // ----------------------------------------
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  task conclude;
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    wadr <= a;
    wdat <= d;
    sel <= 4'hF;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    check(q, e);
  endtask
  task wwr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task pchk(input addr_t a, input byte_t e);
    logic [8:0] q;
    prog_u.prd(a, q);
    check({23'h00_0000, q}, {24'h00_0000, e});
  endtask
  task cmd(input byte_t d);
    prog_u.pwr(19'h0_0000, d);
  endtask
  task wirq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    check({31'h0000_0000, irq}, 32'h0000_0001);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(8'h04, 32'h0000_0000);
    rchk(8'h00, 32'h0000_0001);
    rchk(8'h0C, 32'h0000_0000);
    rchk(8'h40, 32'h0000_0000);
    wwr(8'h0C, 32'h0000_0007);
    rchk(8'h0C, 32'h0000_0007);
    cmd(8'h20);
    cmd(8'h20);
    pchk(19'h0_0000, 8'h00);
    wirq();
    pchk(19'h0_0000, 8'hC0);
    rchk(8'h08, 32'h0000_0002);
    rchk(8'h08, 32'h0000_0000);
    cmd(8'h40);
    for (int i = 0; i < 128; i++) begin
      prog_u.pwr(addr_t'(128 + i), byte_t'(i));
    end
    pchk(19'h0_0000, 8'h00);
    wirq();
    pchk(19'h0_0000, 8'hC0);
    rchk(8'h08, 32'h0000_0001);
    cmd(8'h00);
    pchk(19'h0_0083, 8'h03);
    pchk(19'h0_00FF, 8'h7F);
    pchk(19'h0_0005, 8'hFF);
    // Block 0x80 already holds data: a non-erased target must end abnormally
    cmd(8'h40);
    for (int i = 0; i < 128; i++) begin
      prog_u.pwr((i == 0) ? 19'h0_0080 : 19'h0_0000, (i == 0) ? 8'h00 : 8'hFF);
    end
    wirq();
    rchk(8'h08, 32'h0000_0005);
    cmd(8'h71);
    cmd(8'h71);
    pchk(19'h0_0000, 8'hA2);
    wwr(8'h0C, 32'h0000_0000);
    cmd(8'h33);
    check({31'h0000_0000, irq}, 32'h0000_0000);
    wwr(8'h0C, 32'h0000_0007);
    pchk(19'h0_0000, 8'h80);
    check({31'h0000_0000, irq}, 32'h0000_0001);
    cmd(8'h71);
    cmd(8'h71);
    pchk(19'h0_0000, 8'hC0);
    rchk(8'h08, 32'h0000_0004);
    cmd(8'h25);
    cmd(8'h25);
    wirq();
    rchk(8'h08, 32'h0000_0002);
    cmd(8'h05);
    pchk(19'h0_0003, 8'hFF);
    // Aligned block, but beyond the shrunk boot array
    cmd(8'h45);
    for (int i = 0; i < 128; i++) begin
      prog_u.pwr((i == 0) ? 19'h0_0080 : 19'h0_0000, 8'hFF);
    end
    wirq();
    cmd(8'h71);
    cmd(8'h71);
    pchk(19'h0_0000, 8'hA1);
    // A failed program still reports done, together with the abnormal-end bit
    rchk(8'h08, 32'h0000_0005);
    wwr(8'h00, 32'h0000_0000);
    cmd(8'h33);
    rchk(8'h08, 32'h0000_0000);
    wwr(8'h00, 32'h0000_0001);
    check({31'h0000_0000, oen}, 32'h0000_0001);
    conclude();
  end
endmodule
